// [common/tla_pkg.sv]
// Package for the temperature limit and alarm register bank
package tla_pkg;

    // ******************************
    // Sizes
    // ******************************
    localparam int NCH = 4;

    // ******************************
    // Register offsets
    // ******************************
    localparam logic [7:0] A_STATUS = 8'h02;
    localparam logic [7:0] A_CFG = 8'h03;
    localparam logic [7:0] A_CFG_AL = 8'h09;
    localparam logic [7:0] A_INT_HI = 8'h05;
    localparam logic [7:0] A_INT_LO = 8'h06;
    localparam logic [7:0] A_R1_HI = 8'h07;
    localparam logic [7:0] A_R1_LO = 8'h08;
    localparam logic [7:0] A_INT_HI_AL = 8'h0b;
    localparam logic [7:0] A_INT_LO_AL = 8'h0c;
    localparam logic [7:0] A_R1_HI_AL = 8'h0d;
    localparam logic [7:0] A_R1_LO_AL = 8'h0e;
    localparam logic [7:0] A_ONESHOT = 8'h0f;
    localparam logic [7:0] A_SPARE_A = 8'h11;
    localparam logic [7:0] A_SPARE_B = 8'h12;
    localparam logic [7:0] A_R1_HI_FR = 8'h13;
    localparam logic [7:0] A_R1_LO_FR = 8'h14;
    localparam logic [7:0] A_R2_HI = 8'h15;
    localparam logic [7:0] A_R2_LO = 8'h16;
    localparam logic [7:0] A_R2_HI_FR = 8'h17;
    localparam logic [7:0] A_R2_LO_FR = 8'h18;
    localparam logic [7:0] A_R1_CRIT = 8'h19;
    localparam logic [7:0] A_R2_CRIT = 8'h1a;
    localparam logic [7:0] A_FAULT = 8'h1b;
    localparam logic [7:0] A_MASK = 8'h1f;
    localparam logic [7:0] A_INT_CRIT = 8'h20;
    localparam logic [7:0] A_HYST = 8'h21;
    localparam logic [7:0] A_R3_HI = 8'h2c;
    localparam logic [7:0] A_R3_LO = 8'h2d;
    localparam logic [7:0] A_R3_HI_FR = 8'h2e;
    localparam logic [7:0] A_R3_LO_FR = 8'h2f;
    localparam logic [7:0] A_R3_CRIT = 8'h30;
    localparam logic [7:0] A_HI_STAT = 8'h35;
    localparam logic [7:0] A_LO_STAT = 8'h36;
    localparam logic [7:0] A_CRIT_STAT = 8'h37;

    // ******************************
    // Reset values and field positions
    // ******************************
    localparam logic [7:0] RST_HI = 8'h55;
    localparam logic [7:0] RST_LO = 8'h00;
    localparam logic [7:0] RST_CRIT = 8'h55;
    localparam logic [7:0] RST_HYST = 8'h0a;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam int CFG_MASK_ALL = 7;
    localparam int CFG_STANDBY = 6;
    localparam int ST_BUSY = 7;
    localparam int ST_HIGH = 4;
    localparam int ST_LOW = 3;
    localparam int ST_FAULT = 2;
    localparam int ST_CRIT = 1;

    // ******************************
    // Types
    // ******************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tla_reg_req_t;

    typedef struct packed {
        logic [NCH-1:0][10:0] temp;
        logic [NCH-1:1] fault;
    } tla_conv_res_t;

    typedef enum logic {
        CS_IDLE,
        CS_BUSY
    } tla_conv_state_t;

endpackage

// [design/tla_regs.sv]
// Limit, alarm and housekeeping register bank of a four channel temperature monitor
`timescale 1ns/1ps

// Notes on behaviour
// - Above high limit: flag, warn unless masked
// - At or below low limit: flag, warn
// - Aliased limit addresses share one storage
// - Standby limits apply from next cycle
// - Two spare bytes, plain, reset zero
// - One-shot write in idle standby converts
// - One-shot write while active is ignored
// - Above critical limit drives critical output
// - Critical output never masked
// - Critical release below limit minus hysteresis
// - Fault bits 3..1 mark remote channels
// - Fault register clears after read
// - Masked channel never raises warning
// - Mask bits 3..1 remotes, 0 internal
// - Status: busy, high, low, fault, critical
// - Status flags clear on detail read
// - Standby bit stops conversions, else continuous
// - Global mask blocks warning only, status still updates
module tla_regs (
    input wire logic clk,
    input wire logic rst,
    input wire tla_pkg::tla_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic conv_start,
    input wire logic conv_done,
    input wire tla_pkg::tla_conv_res_t conv_res,
    output logic warn_oe,
    output logic crit_oe
);

    // ******************************
    // Storage
    // ******************************
    // Host-visible limits, one entry per channel, entry 0 internal
    // The internal channel has no fraction bytes; its entries stay zero
    logic [7:0] hi_int_r [tla_pkg::NCH];
    logic [7:0] lo_int_r [tla_pkg::NCH];
    logic [2:0] hi_frac_r [tla_pkg::NCH];
    logic [2:0] lo_frac_r [tla_pkg::NCH];
    logic [7:0] crit_r [tla_pkg::NCH];

    // Shared settings and the two plain spare bytes
    logic [7:0] hyst_r;
    logic [7:0] spare_a_r;
    logic [7:0] spare_b_r;
    logic [7:0] cfg_r;
    logic [3:0] mask_r;

    // Limits frozen at the start of a conversion cycle
    // High and low take eleven bits: integer byte then three fraction bits; critical and hysteresis whole bytes
    logic [10:0] cap_hi_r [tla_pkg::NCH];
    logic [10:0] cap_lo_r [tla_pkg::NCH];
    logic [7:0] cap_crit_r [tla_pkg::NCH];
    logic [7:0] cap_hyst_r;

    // Sticky flags, bit n is channel n, cleared by a read
    logic [3:1] fault_r;
    logic [3:0] hi_stat_r;
    logic [3:0] lo_stat_r;
    logic [3:0] crit_stat_r;

    // Critical latch per channel, held through the hysteresis band
    logic [3:0] crit_act_r;

    // Output flops; every pin leaves straight from one of these
    logic [7:0] rdata_r;
    logic start_r;
    logic warn_r;
    logic crit_r_out;

    // Converter sequencer state
    tla_pkg::tla_conv_state_t state_r;

    // Decoded bus fields and sequencing helpers
    logic busy;
    logic standby;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wd;
    logic start_nxt;
    logic done_ok;

    // Per-channel compare results, only used while a result lands
    logic [3:0] over_hi;
    logic [3:0] under_lo;
    logic [3:0] over_crit;
    logic [3:0] below_rel;

    // Read mux
    logic [7:0] status;
    logic [7:0] rd_val;

    assign wr = reg_req.wr;
    assign rd = reg_req.rd;
    assign addr = reg_req.addr;
    assign wd = reg_req.wdata;
    assign busy = (state_r == tla_pkg::CS_BUSY);
    assign standby = cfg_r[tla_pkg::CFG_STANDBY];
    assign done_ok = conv_done && busy;

    // ******************************
    // Conversion sequencing
    // ******************************

    // Active mode restarts as soon as idle; standby waits for a one-shot
    // A one-shot that finds the sequencer busy, or the device active, has
    // nothing to start and is dropped rather than queued
    always_comb begin
        start_nxt = 1'b0;
        if (!busy) begin
            if (!standby) begin
                start_nxt = 1'b1;
            end else if (wr && addr == tla_pkg::A_ONESHOT) begin
                start_nxt = 1'b1;
            end
        end
    end

    // One-shot writes while converting fall through start_nxt unused
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= tla_pkg::CS_IDLE;
        end else begin
            case (state_r)
                tla_pkg::CS_IDLE: begin
                    if (start_nxt) begin
                        state_r <= tla_pkg::CS_BUSY;
                    end
                end
                tla_pkg::CS_BUSY: begin
                    if (conv_done) begin
                        state_r <= tla_pkg::CS_IDLE;
                    end
                end
                default: begin
                    state_r <= tla_pkg::CS_IDLE;
                end
            endcase
        end
    end

    // Start pulse to the converter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_r <= 1'b0;
        end else begin
            start_r <= start_nxt;
        end
    end

    // ******************************
    // Register writes
    // ******************************

    // Aliased addresses land on the same flops
    // The one-shot offset is decoded by the sequencer and never stored
    // Unmapped, read-only and write-only offsets fall to the default
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < tla_pkg::NCH; i++) begin
                hi_int_r[i] <= tla_pkg::RST_HI;
                lo_int_r[i] <= tla_pkg::RST_LO;
                hi_frac_r[i] <= 3'h0;
                lo_frac_r[i] <= 3'h0;
                crit_r[i] <= tla_pkg::RST_CRIT;
            end
            hyst_r <= tla_pkg::RST_HYST;
            spare_a_r <= tla_pkg::RST_ZERO;
            spare_b_r <= tla_pkg::RST_ZERO;
            cfg_r <= tla_pkg::RST_ZERO;
            mask_r <= 4'h0;
        end else if (wr) begin
            case (addr)
                tla_pkg::A_INT_HI, tla_pkg::A_INT_HI_AL: hi_int_r[0] <= wd;
                tla_pkg::A_INT_LO, tla_pkg::A_INT_LO_AL: lo_int_r[0] <= wd;
                tla_pkg::A_R1_HI, tla_pkg::A_R1_HI_AL: hi_int_r[1] <= wd;
                tla_pkg::A_R1_LO, tla_pkg::A_R1_LO_AL: lo_int_r[1] <= wd;
                tla_pkg::A_R1_HI_FR: hi_frac_r[1] <= wd[7:5];
                tla_pkg::A_R1_LO_FR: lo_frac_r[1] <= wd[7:5];
                tla_pkg::A_R2_HI: hi_int_r[2] <= wd;
                tla_pkg::A_R2_LO: lo_int_r[2] <= wd;
                tla_pkg::A_R2_HI_FR: hi_frac_r[2] <= wd[7:5];
                tla_pkg::A_R2_LO_FR: lo_frac_r[2] <= wd[7:5];
                tla_pkg::A_R3_HI: hi_int_r[3] <= wd;
                tla_pkg::A_R3_LO: lo_int_r[3] <= wd;
                tla_pkg::A_R3_HI_FR: hi_frac_r[3] <= wd[7:5];
                tla_pkg::A_R3_LO_FR: lo_frac_r[3] <= wd[7:5];
                tla_pkg::A_INT_CRIT: crit_r[0] <= wd;
                tla_pkg::A_R1_CRIT: crit_r[1] <= wd;
                tla_pkg::A_R2_CRIT: crit_r[2] <= wd;
                tla_pkg::A_R3_CRIT: crit_r[3] <= wd;
                tla_pkg::A_HYST: hyst_r <= wd;
                tla_pkg::A_SPARE_A: spare_a_r <= wd;
                tla_pkg::A_SPARE_B: spare_b_r <= wd;
                tla_pkg::A_CFG, tla_pkg::A_CFG_AL: cfg_r <= wd;
                tla_pkg::A_MASK: mask_r <= wd[3:0];
                default: begin
                end
            endcase
        end
    end

    // ******************************
    // Limit capture
    // ******************************

    // Snapshot at cycle start, so mid-cycle writes cannot tear a compare
    // Limitation: a write in the same cycle as a start misses this capture
    // and only takes effect from the following cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < tla_pkg::NCH; i++) begin
                cap_hi_r[i] <= {tla_pkg::RST_HI, 3'h0};
                cap_lo_r[i] <= {tla_pkg::RST_LO, 3'h0};
                cap_crit_r[i] <= tla_pkg::RST_CRIT;
            end
            cap_hyst_r <= tla_pkg::RST_HYST;
        end else if (start_nxt) begin
            for (int i = 0; i < tla_pkg::NCH; i++) begin
                cap_hi_r[i] <= {hi_int_r[i], hi_frac_r[i]};
                cap_lo_r[i] <= {lo_int_r[i], lo_frac_r[i]};
                cap_crit_r[i] <= crit_r[i];
            end
            cap_hyst_r <= hyst_r;
        end
    end

    // ******************************
    // Per-channel comparison
    // ******************************
    for (genvar g = 0; g < tla_pkg::NCH; g++) begin : g_ch
        logic [10:0] t;
        logic [7:0] rel;
        // Compares run every cycle; only the done cycle's result is kept
        // Internal fraction is dropped; its limit fraction stays zero
        assign t = (g == 0) ? {conv_res.temp[g][10:3], 3'h0} : conv_res.temp[g];
        // Saturate at zero: a hysteresis above the limit never releases
        assign rel = (cap_crit_r[g] >= cap_hyst_r) ? 8'(cap_crit_r[g] - cap_hyst_r) : 8'h00;
        assign over_hi[g] = t > cap_hi_r[g];
        assign under_lo[g] = t <= cap_lo_r[g];
        assign over_crit[g] = t > {cap_crit_r[g], 3'h0};
        assign below_rel[g] = t < {rel, 3'h0};
    end

    // ******************************
    // Sticky status with read clear
    // ******************************

    // A result landing in the clearing read cycle is kept
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hi_stat_r <= 4'h0;
            lo_stat_r <= 4'h0;
            crit_stat_r <= 4'h0;
            fault_r <= 3'h0;
        end else begin
            hi_stat_r <= ((rd && addr == tla_pkg::A_HI_STAT) ? 4'h0 : hi_stat_r)
                | (done_ok ? over_hi : 4'h0);
            lo_stat_r <= ((rd && addr == tla_pkg::A_LO_STAT) ? 4'h0 : lo_stat_r)
                | (done_ok ? under_lo : 4'h0);
            crit_stat_r <= ((rd && addr == tla_pkg::A_CRIT_STAT) ? 4'h0 : crit_stat_r)
                | (done_ok ? over_crit : 4'h0);
            fault_r <= ((rd && addr == tla_pkg::A_FAULT) ? 3'h0 : fault_r)
                | (done_ok ? conv_res.fault : 3'h0);
        end
    end

    // Critical state per channel holds until the hysteresis point
    // Release point is limit minus hysteresis, in whole degrees
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            crit_act_r <= 4'h0;
        end else if (done_ok) begin
            crit_act_r <= over_crit | (crit_act_r & ~below_rel);
        end
    end

    // ******************************
    // Alarm pins
    // ******************************

    // Warning follows unmasked high, low and fault flags; internal has no fault source
    // Trade-off: interrupt style, so the pin drops only once the host reads the flags or masks them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            warn_r <= 1'b0;
        end else begin
            warn_r <= !cfg_r[tla_pkg::CFG_MASK_ALL]
                && (|((hi_stat_r | lo_stat_r) & ~mask_r)
                || |(fault_r & ~mask_r[3:1]));
        end
    end

    // No mask of any kind reaches this pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            crit_r_out <= 1'b0;
        end else begin
            crit_r_out <= |crit_act_r;
        end
    end

    // ******************************
    // Read path
    // ******************************
    // Summary bits are ORs of the detail flags, so they clear with them
    always_comb begin
        status = 8'h00;
        status[tla_pkg::ST_BUSY] = busy;
        status[tla_pkg::ST_HIGH] = |hi_stat_r;
        status[tla_pkg::ST_LOW] = |lo_stat_r;
        status[tla_pkg::ST_FAULT] = |fault_r;
        status[tla_pkg::ST_CRIT] = |crit_stat_r;
    end

    // Unmapped and write-only addresses read zero
    always_comb begin
        case (addr)
            tla_pkg::A_STATUS: rd_val = status;
            tla_pkg::A_CFG, tla_pkg::A_CFG_AL: rd_val = cfg_r;
            tla_pkg::A_INT_HI, tla_pkg::A_INT_HI_AL: rd_val = hi_int_r[0];
            tla_pkg::A_INT_LO, tla_pkg::A_INT_LO_AL: rd_val = lo_int_r[0];
            tla_pkg::A_R1_HI, tla_pkg::A_R1_HI_AL: rd_val = hi_int_r[1];
            tla_pkg::A_R1_LO, tla_pkg::A_R1_LO_AL: rd_val = lo_int_r[1];
            tla_pkg::A_R1_HI_FR: rd_val = {hi_frac_r[1], 5'h00};
            tla_pkg::A_R1_LO_FR: rd_val = {lo_frac_r[1], 5'h00};
            tla_pkg::A_R2_HI: rd_val = hi_int_r[2];
            tla_pkg::A_R2_LO: rd_val = lo_int_r[2];
            tla_pkg::A_R2_HI_FR: rd_val = {hi_frac_r[2], 5'h00};
            tla_pkg::A_R2_LO_FR: rd_val = {lo_frac_r[2], 5'h00};
            tla_pkg::A_R3_HI: rd_val = hi_int_r[3];
            tla_pkg::A_R3_LO: rd_val = lo_int_r[3];
            tla_pkg::A_R3_HI_FR: rd_val = {hi_frac_r[3], 5'h00};
            tla_pkg::A_R3_LO_FR: rd_val = {lo_frac_r[3], 5'h00};
            tla_pkg::A_INT_CRIT: rd_val = crit_r[0];
            tla_pkg::A_R1_CRIT: rd_val = crit_r[1];
            tla_pkg::A_R2_CRIT: rd_val = crit_r[2];
            tla_pkg::A_R3_CRIT: rd_val = crit_r[3];
            tla_pkg::A_HYST: rd_val = hyst_r;
            tla_pkg::A_SPARE_A: rd_val = spare_a_r;
            tla_pkg::A_SPARE_B: rd_val = spare_b_r;
            tla_pkg::A_FAULT: rd_val = {4'h0, fault_r, 1'b0};
            tla_pkg::A_MASK: rd_val = {4'h0, mask_r};
            tla_pkg::A_HI_STAT: rd_val = {4'h0, hi_stat_r};
            tla_pkg::A_LO_STAT: rd_val = {4'h0, lo_stat_r};
            tla_pkg::A_CRIT_STAT: rd_val = {4'h0, crit_stat_r};
            default: rd_val = 8'h00;
        endcase
    end

    // Read data is held until the next read
    // Clear-on-read side effects live in the flag process above
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (rd) begin
            rdata_r <= rd_val;
        end
    end

    assign reg_rdata = rdata_r;
    assign conv_start = start_r;
    assign warn_oe = warn_r;
    assign crit_oe = crit_r_out;

endmodule

// [verif/tla_regs_props.sv]
// Port-level checker for the limit and alarm register bank
`timescale 1ns/1ps
module tla_regs_props (
    input wire logic clk,
    input wire logic rst,
    input wire tla_pkg::tla_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic conv_start,
    input wire logic conv_done,
    input wire tla_pkg::tla_conv_res_t conv_res,
    input wire logic warn_oe,
    input wire logic crit_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic rd_fault;
    // Read of the fault source register, used by two checks
    assign rd_fault = reg_req.rd && reg_req.addr == tla_pkg::A_FAULT;

    // ******************************
    // Properties
    // ******************************
    // Critical moves, and warning rises, only two edges after a result lands or, for warning only, after any write
    property p_crit_rise;
        $rose(crit_oe) |-> $past(conv_done, 2);
    endproperty
    a_crit_rise: assert property (p_crit_rise) else $error("critical output rose without a result");
    property p_crit_fall;
        $fell(crit_oe) |-> $past(conv_done, 2);
    endproperty
    a_crit_fall: assert property (p_crit_fall) else $error("critical output fell without a result");
    property p_warn_rise;
        $rose(warn_oe) |-> $past(conv_done, 2) || $past(reg_req.wr, 2);
    endproperty
    a_warn_rise: assert property (p_warn_rise) else $error("warning rose without a cause");
    property p_fault_bits;
        rd_fault |=> reg_rdata[7:4] == 4'h0 && !reg_rdata[0];
    endproperty
    a_fault_bits: assert property (p_fault_bits) else $error("fault source unused bits set");
    // Second of two back-to-back reads sees the cleared value
    property p_fault_clr;
        rd_fault && !conv_done ##1 rd_fault && !conv_done |=> reg_rdata == 8'h00;
    endproperty
    a_fault_clr: assert property (p_fault_clr) else $error("fault source not cleared by read");
    property p_oneshot_rd;
        reg_req.rd && reg_req.addr == tla_pkg::A_ONESHOT |=> reg_rdata == 8'h00;
    endproperty
    a_oneshot_rd: assert property (p_oneshot_rd) else $error("one-shot register read not zero");
    property p_start_pulse;
        conv_start |=> !conv_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse longer than one cycle");
    property p_spare;
        reg_req.wr && reg_req.addr == tla_pkg::A_SPARE_A ##1 reg_req.rd && reg_req.addr == tla_pkg::A_SPARE_A
            |=> reg_rdata == $past(reg_req.wdata, 2);
    endproperty
    a_spare: assert property (p_spare) else $error("spare byte readback wrong");
    property p_alias;
        reg_req.wr && reg_req.addr == tla_pkg::A_R1_LO_AL ##1 reg_req.rd && reg_req.addr == tla_pkg::A_R1_LO
            |=> reg_rdata == $past(reg_req.wdata, 2);
    endproperty
    a_alias: assert property (p_alias) else $error("aliased limit readback wrong");
    c_warn: cover property ($rose(warn_oe));
    c_crit: cover property ($fell(crit_oe));
    c_start: cover property (conv_start);
endmodule

bind tla_regs tla_regs_props tla_regs_props_inst (.clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .conv_start(conv_start), .conv_done(conv_done), .conv_res(conv_res), .warn_oe(warn_oe), .crit_oe(crit_oe));

// [verif/tla_conv_model.sv]
// Converter stand-in answering each start pulse after a fixed delay
`timescale 1ns/1ps
module tla_conv_model #(
    parameter int DLY = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic conv_start,
    input wire tla_pkg::tla_conv_res_t res_set,
    output logic conv_done,
    output tla_pkg::tla_conv_res_t conv_res
);
    int cnt;
    // Countdown from the start pulse; zero means idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            conv_done <= 1'b0;
        end else begin
            conv_done <= (cnt == 1);
            if (conv_start) cnt <= DLY;
            else if (cnt > 0) cnt <= cnt - 1;
        end
    end
    // Inverted outside done so stale results never look valid
    assign conv_res = conv_done ? res_set : ~res_set;
endmodule

// [verif/tla_regs_bench.sv]
// Self-checking bench for the limit and alarm register bank
`timescale 1ns/1ps
module tla_regs_bench;
    logic clk, rst, conv_start, conv_done, warn_oe, crit_oe;
    logic [7:0] reg_rdata;
    tla_pkg::tla_reg_req_t reg_req;
    tla_pkg::tla_conv_res_t conv_res, res_set;
    int miscompares = 0;
    int checks_done = 0;
    logic [7:0] ra[8] = '{8'h05, 8'h06, 8'h13, 8'h1a, 8'h1b, 8'h1f, 8'h21, 8'h12};
    logic [7:0] rv[8] = '{8'h55, 8'h00, 8'h00, 8'h55, 8'h00, 8'h00, 8'h0a, 8'h00};

    tla_regs tla_regs_inst (.clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .conv_start(conv_start),
        .conv_done(conv_done), .conv_res(conv_res), .warn_oe(warn_oe), .crit_oe(crit_oe));
    tla_conv_model tla_conv_model_inst (.clk(clk), .rst(rst), .conv_start(conv_start), .res_set(res_set),
        .conv_done(conv_done), .conv_res(conv_res));

    // Free-running 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ******************************
    // Bus and check helpers
    // ******************************
    task automatic results;
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Requests change just after an edge and are held through the taking edge
    task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
        reg_req = '{w, !w, a, d};
        @(posedge clk);
        #1;
    endtask
    task automatic idle;
        reg_req = '0;
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        op(1'b1, a, d);
        idle();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        op(1'b0, a, 8'h00);
        chk(reg_rdata & m, e);
        idle();
    endtask
    task automatic pins(input logic [1:0] e);
        chk({6'h0, warn_oe, crit_oe}, {6'h0, e});
    endtask
    // Waits for n results, then lets flags and pins settle
    task automatic wconv(input int n);
        int k = 0;
        while (n > 0) begin
            @(posedge clk);
            #1;
            k++;
            if (conv_done === 1'b1) n--;
            if (k > 400) begin
                miscompares++;
                $display("Error at %0t: no conversion result", $time);
                results();
            end
        end
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic norm;
        res_set.fault = 3'h0;
        for (int i = 0; i < 4; i++) res_set.temp[i] = 11'h140;
    endtask

    // ******************************
    // Scenarios
    // ******************************
    task automatic t_reset_vals;
        for (int i = 0; i < 8; i++) rd(ra[i], rv[i], 8'hff);
        pins(2'b00);
    endtask
    // Ends on a result captured with the R1 low write, so it still uses 0x12; the next capture has all limits restored
    task automatic t_rw;
        wr(8'h0b, 8'h3c);
        rd(8'h05, 8'h3c, 8'hff);
        op(1'b1, 8'h0e, 8'h12);
        op(1'b0, 8'h08, 8'h00);
        chk(reg_rdata, 8'h12);
        op(1'b1, 8'h11, 8'ha5);
        op(1'b0, 8'h11, 8'h00);
        chk(reg_rdata, 8'ha5);
        idle();
        wr(8'h12, 8'h5a);
        rd(8'h12, 8'h5a, 8'hff);
        rd(8'h0f, 8'h00, 8'hff);
        rd(8'h40, 8'h00, 8'hff);
        wr(8'h0b, 8'h55);
        wr(8'h08, 8'h00);
        wconv(1);
    endtask
    // Fraction above limit counts on a remote, not on the internal channel
    // High and critical limits share a default, so the remote trips both
    task automatic t_high;
        res_set.temp[0] = {8'h55, 3'h7};
        res_set.temp[1] = {8'h55, 3'h1};
        wconv(1);
        pins(2'b11);
        rd(8'h02, 8'h12, 8'h7f);
        norm();
        wconv(1);
        rd(8'h35, 8'h02, 8'hff);
        rd(8'h37, 8'h02, 8'hff);
        rd(8'h02, 8'h00, 8'h7f);
        pins(2'b00);
    endtask
    task automatic t_low;
        wr(8'h1f, 8'h04);
        res_set.temp[2] = 11'h000;
        wconv(2);
        pins(2'b00);
        rd(8'h36, 8'h04, 8'hff);
        wr(8'h1f, 8'h00);
        wconv(1);
        pins(2'b10);
        norm();
        wconv(1);
        op(1'b0, 8'h36, 8'h00);
        idle();
        rd(8'h36, 8'h00, 8'hff);
        pins(2'b00);
    endtask
    task automatic t_fault_crit;
        wr(8'h03, 8'h80);
        wr(8'h1f, 8'h0f);
        res_set.fault[3] = 1'b1;
        res_set.temp[1] = {8'h56, 3'h0};
        wconv(2);
        pins(2'b01);
        rd(8'h02, 8'h16, 8'h7f);
        norm();
        res_set.temp[1] = {8'h4c, 3'h0};
        wconv(2);
        pins(2'b01);
        op(1'b0, 8'h1b, 8'h00);
        chk(reg_rdata, 8'h08);
        op(1'b0, 8'h1b, 8'h00);
        chk(reg_rdata, 8'h00);
        idle();
        res_set.temp[1] = {8'h4a, 3'h7};
        wconv(2);
        pins(2'b00);
        rd(8'h37, 8'h02, 8'hff);
        op(1'b0, 8'h35, 8'h00);
        idle();
        wr(8'h03, 8'h00);
        wr(8'h1f, 8'h00);
        norm();
    endtask
    task automatic t_standby;
        int n = 0;
        wr(8'h03, 8'h40);
        wconv(1);
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            #1;
            if (conv_start === 1'b1) n++;
        end
        chk(8'(n), 8'h00);
        wr(8'h07, 8'h20);
        rd(8'h35, 8'h00, 8'hff);
        wr(8'h0f, 8'h00);
        wconv(1);
        pins(2'b10);
        rd(8'h02, 8'h10, 8'hff);
        rd(8'h35, 8'h02, 8'hff);
        rd(8'h02, 8'h00, 8'hff);
    endtask

    // Reset, then the scenarios in turn
    initial begin
        reg_req = '0;
        norm();
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset_vals();
        t_rw();
        t_high();
        t_low();
        t_fault_crit();
        t_standby();
        results();
    end
endmodule
